// ### hw/mcu_clock_gating_ctrl.v
`include "clock_gating_regs.vh"

module mcu_clock_gating_ctrl
(
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // special-function-register bus from the cpu
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output wire sfr_hit,
    // power-down wake sources and clock state
    input wire ext_irq_wake,
    input wire clock_change_status,
    output wire power_down_request,
    output wire wakeup_rc_clock_flag,
    output wire mcu_clock_from_rc,
    // peripheral operating clock
    input wire periph_clk,
    output wire [7:0] gated_clk_zero,
    output wire [7:0] gated_clk_one,
    output wire [7:0] gated_clk_two,
    output wire [3:0] gated_clk_three
);

    // ****************************************************************
    // reset release and input synchronisers
    // ****************************************************************
    reg [1:0] rst_sync;
    wire rst_n = rst_sync[1];
    reg [1:0] wake_sync;
    reg [1:0] chg_sync;

    // reset asserts at once but releases only on a clock edge
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    // external inputs pass two flops before use
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_sync <= 2'h0;
            chg_sync <= 2'h0;
        end
        else
        begin
            wake_sync <= {wake_sync[0], ext_irq_wake};
            chg_sync <= {chg_sync[0], clock_change_status};
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    reg [7:0] gate_zero;
    reg [7:0] gate_one;
    reg [7:0] gate_two;
    reg [3:0] gate_three;
    reg wake_flag;
    reg power_down;
    reg clock_change;

    // write strobes for the two flag registers
    wire wr_ref = sfr_wr && (sfr_addr == `ADDR_REF_CLOCK_CONTROL_TWO);
    wire wr_power_ctl = sfr_wr && (sfr_addr == `ADDR_POWER_CONTROL);
    wire pd_start = wr_power_ctl && sfr_wdata[`BIT_POWER_DOWN] && !power_down;

    // gate bits: plain read/write, reset values per register
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_zero <= `RST_GATE_ZERO;
            gate_one <= `RST_GATE_ONE;
            gate_two <= `RST_GATE_TWO;
            gate_three <= `RST_GATE_THREE;
        end
        else if (sfr_wr)
        begin
            case (sfr_addr)
                `ADDR_PERIPH_CLOCK_GATE_ZERO: gate_zero <= sfr_wdata;
                `ADDR_PERIPH_CLOCK_GATE_ONE: gate_one <= sfr_wdata;
                `ADDR_PERIPH_CLOCK_GATE_TWO: gate_two <= sfr_wdata;
                `ADDR_PERIPH_CLOCK_GATE_THREE: gate_three <= sfr_wdata[`GATE_THREE_BITS-1:0];
                default: gate_zero <= gate_zero;
            endcase
        end
    end

    // power-down bit: software sets, a synchronised wake event clears;
    // the wake wins so a late interrupt is never missed
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            power_down <= 1'b0;
        else if (wake_sync[1])
            power_down <= 1'b0;
        else if (wr_power_ctl)
            power_down <= sfr_wdata[`BIT_POWER_DOWN];
    end

    // wake-up flag: set on power-down entry, only a written 0 clears it;
    // set beats a clear landing in the same cycle
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wake_flag <= 1'b0;
        else if (pd_start)
            wake_flag <= 1'b1;
        else if (wr_ref && !sfr_wdata[`BIT_WAKEUP_RC])
            wake_flag <= 1'b0;
    end

    // clock-change status mirrors the clock switcher, read only
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            clock_change <= 1'b0;
        else
            clock_change <= chg_sync[1];
    end

    assign power_down_request = power_down;
    assign wakeup_rc_clock_flag = wake_flag;
    assign mcu_clock_from_rc = wake_flag;

    // ****************************************************************
    // read mux
    // ****************************************************************
    // address decode for the hit flag; the write and read paths decode by case
    function is_mapped;
        input [7:0] addr;
        begin
            case (addr)
                `ADDR_REF_CLOCK_CONTROL_TWO: is_mapped = 1'b1;
                `ADDR_PERIPH_CLOCK_GATE_ZERO: is_mapped = 1'b1;
                `ADDR_PERIPH_CLOCK_GATE_ONE: is_mapped = 1'b1;
                `ADDR_PERIPH_CLOCK_GATE_TWO: is_mapped = 1'b1;
                `ADDR_PERIPH_CLOCK_GATE_THREE: is_mapped = 1'b1;
                `ADDR_POWER_CONTROL: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // the cpu's other sfrs answer elsewhere, so the hit lets it pick its read source
    assign sfr_hit = is_mapped(sfr_addr);

    // read data registered one cycle after sfr_rd; unmapped reads zero
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
        begin
            case (sfr_addr)
                `ADDR_REF_CLOCK_CONTROL_TWO: sfr_rdata <= {clock_change, wake_flag, 6'h00};
                `ADDR_PERIPH_CLOCK_GATE_ZERO: sfr_rdata <= gate_zero;
                `ADDR_PERIPH_CLOCK_GATE_ONE: sfr_rdata <= gate_one;
                `ADDR_PERIPH_CLOCK_GATE_TWO: sfr_rdata <= gate_two;
                `ADDR_PERIPH_CLOCK_GATE_THREE: sfr_rdata <= {4'h0, gate_three};
                `ADDR_POWER_CONTROL: sfr_rdata <= {6'h00, power_down, 1'b0};
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // glitch-free gating
    // ****************************************************************
    // enables cross into the peripheral clock domain through two flops on its
    // falling edge, so a gate only opens or closes while periph_clk is low and
    // no high phase is ever clipped; the cost is two periph_clk cycles of latency
    // reset may cut a running high phase, but the peripherals sit in reset then too
    wire [27:0] gate_en = {gate_three, gate_two, gate_one, gate_zero};
    reg [27:0] gate_meta;
    reg [27:0] gate_sync;

    // only gate_sync is read by the gating logic
    always @(negedge periph_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_meta <= {`RST_GATE_THREE, `RST_GATE_TWO, `RST_GATE_ONE, `RST_GATE_ZERO};
            gate_sync <= {`RST_GATE_THREE, `RST_GATE_TWO, `RST_GATE_ONE, `RST_GATE_ZERO};
        end
        else
        begin
            gate_meta <= gate_en;
            gate_sync <= gate_meta;
        end
    end

    wire [27:0] gated = gate_sync & {28{periph_clk}};

    // bit 3..1 of gate three drive the port 3, 1 and 0 pin irq blocks
    assign gated_clk_zero = gated[7:0];
    assign gated_clk_one = gated[15:8];
    assign gated_clk_two = gated[23:16];
    assign gated_clk_three = gated[27:24];

endmodule // mcu_clock_gating_ctrl

// ### include/clock_gating_regs.vh
`ifndef CLOCK_GATING_REGS_VH
`define CLOCK_GATING_REGS_VH

// ****************************************************************
// special-function-register addresses
// ****************************************************************
`define ADDR_REF_CLOCK_CONTROL_TWO 8'h8f
`define ADDR_PERIPH_CLOCK_GATE_THREE 8'h92
`define ADDR_PERIPH_CLOCK_GATE_ZERO 8'h98
`define ADDR_PERIPH_CLOCK_GATE_ONE 8'h99
`define ADDR_PERIPH_CLOCK_GATE_TWO 8'h9a
`define ADDR_POWER_CONTROL 8'h87

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define RST_GATE_ZERO 8'h70
`define RST_GATE_ONE 8'h00
`define RST_GATE_TWO 8'h07
`define RST_GATE_THREE 4'h1
`define GATE_THREE_BITS 4
`define BIT_CLOCK_CHANGE 7
`define BIT_WAKEUP_RC 6
`define BIT_POWER_DOWN 1

`endif

// ### tb/clock_gating_properties.sv
module clock_gating_properties
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register bus
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // power-down and clock select
    input wire logic ext_irq_wake,
    input wire logic power_down_request,
    input wire logic wakeup_rc_clock_flag,
    input wire logic mcu_clock_from_rc
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // the wake input reaches the power-down bit two edges late, hence the look back
    chk_rc_select: assert property (mcu_clock_from_rc == wakeup_rc_clock_flag)
        else $error("rc select differs from wake flag");
    chk_pd_sets: assert property ($rose(power_down_request) |-> wakeup_rc_clock_flag)
        else $error("wake flag not set");
    chk_flag_holds: assert property (wakeup_rc_clock_flag && !(sfr_wr && sfr_addr == 8'h8f && !sfr_wdata[6])
        |=> wakeup_rc_clock_flag) else $error("wake flag lost");
    chk_flag_clear: assert property (sfr_wr && sfr_addr == 8'h8f && !sfr_wdata[6] |=> !wakeup_rc_clock_flag)
        else $error("wake flag not cleared");
    chk_pd_start: assert property (sfr_wr && sfr_addr == 8'h87 && sfr_wdata[1] && !$past(ext_irq_wake, 2)
        |=> power_down_request) else $error("power-down not started");
    chk_wake_ends: assert property (ext_irq_wake [*5] |-> !power_down_request)
        else $error("power-down not ended");
    chk_ctl_read: assert property (sfr_rd && sfr_addr == 8'h8f
        |=> sfr_rdata[6:0] == {$past(wakeup_rc_clock_flag), 6'h00}) else $error("control read wrong");
    chk_gate3_top: assert property (sfr_rd && sfr_addr == 8'h92 |=> sfr_rdata[7:4] == 4'h0)
        else $error("gate three top bits set");
endmodule // clock_gating_properties

bind mcu_clock_gating_ctrl clock_gating_properties chk_u (.mclk, .rst_b, .sfr_wr, .sfr_rd, .ext_irq_wake,
    .power_down_request, .wakeup_rc_clock_flag, .mcu_clock_from_rc, .sfr_addr, .sfr_wdata, .sfr_rdata);

// ### tb/periph_clock_sink.sv
module periph_clock_sink
(
    // source clock out, gated clocks back
    output logic periph_clk,
    input wire logic clr,
    input wire logic [27:0] gclk,
    // what the peripherals saw
    output logic [27:0] seen,
    output int runts
);
    timeunit 1ns;
    timeprecision 1ps;
    time t[28];
    initial runts = 0;
    initial periph_clk = 0;
    // free-running at twice the mclk rate, its falling edges landing on mclk edges
    always #10 periph_clk = ~periph_clk;
    // each peripheral notes activity and any high phase cut short
    for (genvar i = 0; i < 28; i++)
    begin : g
        always @(posedge gclk[i] or posedge clr) seen[i] <= !clr;
        always @(posedge gclk[i]) t[i] = $time;
        always @(negedge gclk[i]) if ($time - t[i] < 10) runts++;
    end
endmodule // periph_clock_sink

// ### tb/test_mcu_clock_gating_ctrl.sv
module test_mcu_clock_gating_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_b, sfr_wr, sfr_rd, ext_irq_wake, clock_change_status, periph_clk, clr, hit, rc, wf, pdr;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, g0, g1, g2, v;
    logic [3:0] g3;
    logic [27:0] seen;
    logic [7:0] ad[7] = '{8'h87, 8'h8f, 8'h92, 8'h98, 8'h99, 8'h9a, 8'h80};
    int errors, n_compared, runts, pd, flag, chg, seed = 32'h4854;
    int m[int] = '{8'h92: 1, 8'h98: 8'h70, 8'h99: 0, 8'h9a: 7};

    mcu_clock_gating_ctrl dut_u (.mclk, .rst_b, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .sfr_hit(hit), .ext_irq_wake, .clock_change_status, .power_down_request(pdr), .wakeup_rc_clock_flag(wf),
        .mcu_clock_from_rc(rc), .periph_clk, .gated_clk_zero(g0), .gated_clk_one(g1), .gated_clk_two(g2),
        .gated_clk_three(g3));
    periph_clock_sink far_u (.periph_clk, .clr, .gclk({g3, g2, g1, g0}), .seen, .runts);

    function automatic logic [7:0] mdl(input logic [7:0] a);
        if (a == 8'h87) return pd * 2;
        if (a == 8'h8f) return chg * 128 + flag * 64;
        return m.exists(a) ? m[a] : 0;
    endfunction
    task automatic chk(input string s, input logic [27:0] e, q);
        n_compared++;
        if (e !== q)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, q);
        end
    endtask
    // strobes rise and fall on falling edges, so each is taken at exactly one rising edge
    task automatic wr(input logic [7:0] a, d);
        @(negedge mclk);
        {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge mclk);
        sfr_wr = 0;
        if (a == 8'h87) flag = flag | (d[1] && !pd);
        if (a == 8'h87) pd = d[1];
        if (a == 8'h8f) flag = flag & d[6];
        if (m.exists(a)) m[a] = d & (a == 8'h92 ? 8'h0f : 8'hff);
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge mclk);
        {sfr_addr, sfr_rd} = {a, 1'b1};
        @(negedge mclk);
        sfr_rd = 0;
        chk("sfr_rdata", mdl(a), sfr_rdata);
        chk("sfr_hit", a == 8'h87 || a == 8'h8f || m.exists(a), hit);
        chk("power_down_request", pd, pdr);
        chk("wakeup_rc_clock_flag", flag, wf);
        chk("mcu_clock_from_rc", flag, rc);
    endtask
    task automatic act();
        clr = 1;
        #1 clr = 0;
        repeat (3) @(negedge mclk);
        chk("activity", {m[8'h92][3:0], m[8'h9a][7:0], m[8'h99][7:0], m[8'h98][7:0]}, seen);
    endtask
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial forever #20 mclk = ~mclk;
    // a hang counts as a mismatch
    initial
    begin
        #100us;
        errors++;
        end_of_test();
    end
    initial
    begin
        {rst_b, sfr_wr, sfr_rd, ext_irq_wake, clock_change_status, clr, sfr_addr, sfr_wdata} = 0;
        repeat (12) @(negedge mclk);
        rst_b = 1;
        repeat (3) @(negedge mclk);
        foreach (ad[i]) rd(ad[i]);
        act();
        $display("test reset_values done");
        repeat (16)
        begin
            v = ad[2 + ($random(seed) & 3)];
            wr(v, $random(seed));
            rd(v);
            act();
        end
        wr(8'h80, 8'hff);
        rd(8'h80);
        wr(8'h8f, 8'hff);
        rd(8'h8f);
        $display("test gates done");
        wr(8'h87, 8'h02);
        rd(8'h87);
        rd(8'h8f);
        wr(8'h8f, 8'h40);
        ext_irq_wake = 1;
        repeat (5) @(negedge mclk);
        pd = 0;
        rd(8'h87);
        rd(8'h8f);
        ext_irq_wake = 0;
        wr(8'h8f, 8'h00);
        rd(8'h8f);
        clock_change_status = 1;
        chg = 1;
        repeat (4) @(negedge mclk);
        rd(8'h8f);
        chk("runts", 0, runts);
        $display("test power_down done");
        end_of_test();
    end
endmodule // test_mcu_clock_gating_ctrl
